// ### rtl/sws_sleep_wake_control.sv
// Sleep/wake sequencer, driver control, receiver gating and register slave
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
module sws_sleep_wake_control
  import sws_pkg::*;
#(
  parameter logic [HOLD_W-1:0] HOLD_MIN_TICKS = HOLD_W'(HOLD_MIN_MS * OSC_KHZ),
  parameter logic [HOLD_W-1:0] HOLD_MAX_TICKS = HOLD_W'(HOLD_MAX_MS * OSC_KHZ),
  parameter logic [HOLD_W-1:0] HOLD_DEF_TICKS = HOLD_W'(HOLD_DEF_MS * OSC_KHZ)
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // Host mode pins and transmit data
  input  wire logic              mode_select_bit0,
  input  wire logic              mode_select_bit1,
  input  wire logic              txd_in,
  // Bus and supply sensing
  input  wire sws_sense_s        sense_in,
  // Regulator, load switch and wake flag
  output logic                   regulator_enable_out,
  output logic                   load_switch_closed_out,
  output logic                   high_voltage_wakeup_flag,
  // Transmit driver controls
  output sws_drv_s               transmit_driver,
  // Receive data, open drain
  input  wire logic              rxd_in,
  output logic                   rxd_out,
  output logic                   rxd_oe,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest
);

  sws_mode_e         mode;
  logic              uv;
  logic [DIV_W-1:0]  div_q, div_d;
  logic              tick_q, tick_d;
  logic [HVF_W-1:0]  hvf_q, hvf_d;
  logic              hv_flag_q, hv_flag_d;
  logic              hv_rise;
  logic              hv_rise_q;
  sws_state_e        state_q, state_d;
  logic [HOLD_W-1:0] hold_cnt_q, hold_cnt_d;
  logic [HOLD_W-1:0] hold_q, hold_d;
  logic              reg_en_q, reg_en_d;
  logic [TXH_W-1:0]  txh_q, txh_d;
  sws_drv_s          drv_q, drv_d;
  logic              tx_active;
  logic              bus_receiver_on;
  logic              rxd_oe_q, rxd_oe_d;
  logic              rxd_q;
  logic              ls_q, ls_d;
  logic              wait_q, wait_d;
  logic [31:0]       rdata_q, rdata_d;
  logic [31:0]       status;
  logic [HOLD_W-1:0] wval;

  // Mode pins; undriven pins read low and select sleep
  assign mode = sws_mode_e'({mode_select_bit0, mode_select_bit1});
  assign uv   = sense_in.undervolt;

  // Oscillator tick divider
  always_comb begin
    tick_d = (div_q == OSC_DIV_LAST);
    div_d  = tick_d ? '0 : div_q + DIV_W'(1);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  // Wake-up level deglitch filter
  always_comb begin
    hvf_d = hvf_q;
    if (!sense_in.hv_level) begin
      hvf_d = '0;
    end else if (hvf_q != HV_FILT_LAST) begin
      hvf_d = hvf_q + HVF_W'(1);
    end
    hv_flag_d = sense_in.hv_level && (hv_flag_q || hvf_q == HV_FILT_LAST);
  end

  assign hv_rise = hv_flag_d && !hv_flag_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hvf_q     <= '0;
      hv_flag_q <= 1'b0;
      hv_rise_q <= 1'b0;
    end else begin
      hvf_q     <= hvf_d;
      hv_flag_q <= hv_flag_d;
      hv_rise_q <= hv_rise;
    end
  end

  // Sleep/wake sequencer and regulator hold counter
  always_comb begin
    state_d    = state_q;
    hold_cnt_d = hold_cnt_q;
    case (state_q)
      ST_SLEEP: begin
        // Only a fresh rise wakes; a steady level after hold expiry keeps sleep
        if (hv_rise_q) begin
          state_d    = ST_WAKE;
          hold_cnt_d = hold_q;
        end
      end
      ST_WAKE: begin
        if (mode != MODE_SLEEP) begin
          state_d = ST_ACTIVE;
        end else if (hold_cnt_q == '0) begin
          state_d = ST_SLEEP;
        end else if (hv_rise) begin
          hold_cnt_d = hold_q;
        end else if (tick_q) begin
          hold_cnt_d = hold_cnt_q - HOLD_W'(1);
        end
      end
      ST_ACTIVE: begin
        if (mode == MODE_SLEEP) begin
          state_d    = ST_WAKE;
          hold_cnt_d = hold_q;
        end
      end
      default: begin
        state_d = ST_SLEEP;
      end
    endcase
    reg_en_d = (state_d != ST_SLEEP);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q    <= ST_SLEEP;
      hold_cnt_q <= '0;
      reg_en_q   <= 1'b0;
    end else begin
      state_q    <= state_d;
      hold_cnt_q <= hold_cnt_d;
      reg_en_q   <= reg_en_d;
    end
  end

  // Transmit driver control and post-passive hold
  assign tx_active = (state_q != ST_SLEEP) && !uv;

  always_comb begin
    drv_d.drive  = tx_active && !txd_in;
    drv_d.hv     = tx_active && (mode == MODE_HIGH_VOLTAGE_WAKEUP_FLAG);
    drv_d.shape  = (mode != MODE_HS);
    txh_d        = txh_q;
    if (drv_d.drive) begin
      txh_d = TX_HOLD_TICKS;
    end else if (tick_q && txh_q != '0) begin
      txh_d = txh_q - TXH_W'(1);
    end
    drv_d.enable = tx_active && (drv_d.drive || txh_q != '0);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      txh_q <= '0;
      drv_q <= '0;
    end else begin
      txh_q <= txh_d;
      drv_q <= drv_d;
    end
  end

  // Receiver gating and load switch
  assign bus_receiver_on = !uv && ((state_q != ST_SLEEP) || hv_flag_q);

  always_comb begin
    rxd_oe_d = bus_receiver_on && sense_in.bus_dom;
    ls_d     = !sense_in.gnd_low;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rxd_oe_q <= 1'b0;
      rxd_q    <= 1'b0;
      ls_q     <= 1'b1;
    end else begin
      rxd_oe_q <= rxd_oe_d;
      rxd_q    <= 1'b0;
      ls_q     <= ls_d;
    end
  end

  // Status word
  always_comb begin
    status                                 = '0;
    status[ST_REG_EN]                      = reg_en_q;
    status[ST_HV_FLAG]                     = hv_flag_q;
    status[ST_STATE_LO +: 3]               = state_q;
    status[ST_UV]                          = uv;
    status[ST_GND_LOW]                     = sense_in.gnd_low;
    status[ST_RXD]                         = rxd_in;
    status[ST_MODE_LO +: 2]                = mode;
    status[ST_TX_EN]                       = drv_q.enable;
    status[ST_LOAD_SW]                     = ls_q;
  end

  // Avalon slave, one wait cycle per access
  always_comb begin
    wait_d  = !((avs_read || avs_write) && wait_q);
    rdata_d = rdata_q;
    hold_d  = hold_q;
    wval    = avs_writedata[HOLD_W-1:0];
    if (avs_read && wait_q) begin
      if (avs_address == REG_HOLD) begin
        rdata_d = {{(32-HOLD_W){1'b0}}, hold_q};
      end else if (avs_address == REG_STATUS) begin
        rdata_d = status;
      end else begin
        rdata_d = '0;
      end
    end
    if (avs_write && !wait_q && avs_address == REG_HOLD) begin
      if (|avs_writedata[31:HOLD_W] || wval > HOLD_MAX_TICKS) begin
        hold_d = HOLD_MAX_TICKS;
      end else if (wval < HOLD_MIN_TICKS) begin
        hold_d = HOLD_MIN_TICKS;
      end else begin
        hold_d = wval;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
      hold_q  <= HOLD_DEF_TICKS;
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
      hold_q  <= hold_d;
    end
  end

  // Outputs
  assign regulator_enable_out     = reg_en_q;
  assign load_switch_closed_out   = ls_q;
  assign high_voltage_wakeup_flag = hv_flag_q;
  assign transmit_driver          = drv_q;
  assign rxd_out                  = rxd_q;
  assign rxd_oe                   = rxd_oe_q;
  assign avs_readdata             = rdata_q;
  assign avs_waitrequest          = wait_q;

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence s_wake_seen;
    state_q == ST_SLEEP && hv_rise_q;
  endsequence

  sequence s_sleep_req;
    state_q == ST_ACTIVE && mode == MODE_SLEEP;
  endsequence

  property p_wake_enable;
    s_wake_seen |=> regulator_enable_out && state_q == ST_WAKE;
  endproperty
  a_wake_enable: assert property (p_wake_enable) else $error("no enable on wake");

  property p_sleep_stay;
    state_q == ST_SLEEP && !hv_rise_q |=> state_q == ST_SLEEP && !regulator_enable_out;
  endproperty
  a_sleep_stay: assert property (p_sleep_stay) else $error("left sleep without wake");

  property p_hold_keep;
    state_q == ST_WAKE && hold_cnt_q != '0 |=> regulator_enable_out;
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("enable fell early");

  property p_hold_sleep;
    state_q == ST_WAKE && hold_cnt_q == '0 && mode == MODE_SLEEP
      |=> state_q == ST_SLEEP && !regulator_enable_out;
  endproperty
  a_hold_sleep: assert property (p_hold_sleep) else $error("no sleep after hold");

  property p_hold_start;
    s_sleep_req |=> state_q == ST_WAKE && hold_cnt_q == hold_q ##1 regulator_enable_out;
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("hold not restarted");

  property p_hold_range;
    hold_q >= HOLD_MIN_TICKS && hold_q <= HOLD_MAX_TICKS;
  endproperty
  a_hold_range: assert property (p_hold_range) else $error("hold out of range");

  property p_tick;
    tick_q |-> div_q == '0 ##1 !tick_q;
  endproperty
  a_tick: assert property (p_tick) else $error("tick spacing wrong");

  property p_deglitch;
    $rose(hv_flag_q) |-> $past(hvf_q) == HV_FILT_LAST && $past(sense_in.hv_level);
  endproperty
  a_deglitch: assert property (p_deglitch) else $error("wake flag not filtered");

  property p_tx_hold;
    $fell(drv_q.drive) && !$past(uv) && $past(state_q) != ST_SLEEP |-> drv_q.enable;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("driver hold missing");

  property p_tx_data;
    drv_q.drive == $past(tx_active && !txd_in);
  endproperty
  a_tx_data: assert property (p_tx_data) else $error("transmit not inverted");

  property p_hv_mode;
    drv_q.hv |-> $past(mode) == MODE_HIGH_VOLTAGE_WAKEUP_FLAG;
  endproperty
  a_hv_mode: assert property (p_hv_mode) else $error("wake drive in wrong mode");

  property p_shape;
    !$past(reset) |-> drv_q.shape == ($past(mode) != MODE_HS);
  endproperty
  a_shape: assert property (p_shape) else $error("shaping wrong");

  property p_undervolt;
    $past(uv) |-> !drv_q.enable && !drv_q.drive && !rxd_oe;
  endproperty
  a_undervolt: assert property (p_undervolt) else $error("active in undervoltage");

  property p_load_sw;
    load_switch_closed_out == !$past(sense_in.gnd_low);
  endproperty
  a_load_sw: assert property (p_load_sw) else $error("load switch wrong");

  property p_sleep_quiet;
    state_q == ST_SLEEP && $past(state_q) == ST_SLEEP |-> !regulator_enable_out && !drv_q.enable;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("active in sleep");

endmodule : sws_sleep_wake_control

// ### rtl/sws_pkg.sv
// Constants, types and carriers for the sleep/wake control block
// What this block does
// - A filtered bus wake-up level raises the regulator enable output.
// - Regulator enable stays high for a hold delay after wake signalling.
// - Hold delay over and both mode bits low returns to sleep, even with wake level.
// - Hold delays are timed from an internal 500 kHz oscillator tick.
// - Driver stays enabled for a fixed time after producing a passive level.
// - Wake-up flag is deglitched and feeds mode control and timers.
// - Receiver turns the bus level into a logic zero or one.
// - Driver sends wake-up voltage only in wake-up mode.
// - Edge shaping on in normal rates, bypassed in high speed mode.
// - Undervoltage disables both receiver and driver.
// - Loss of module ground opens the load switch.
// - Too low ground-to-battery voltage counts as ground loss.
// - Mode bits bit0,bit1: 00 sleep, 01 wake-up, 10 high speed, 11 normal.
// - Transmit data is inverted: high leaves bus recessive, low drives dominant.
// - Hold delay from sleep conditions to enable falling is 300 to 1000 ms.
// - Undriven mode pins read low, which means sleep.
package sws_pkg;

  // Clocking
  localparam int CLK_MHZ = 100;
  localparam int OSC_KHZ = 500;
  localparam int OSC_DIV = CLK_MHZ * 1000 / OSC_KHZ;
  localparam int DIV_W   = 8;
  localparam logic [DIV_W-1:0] OSC_DIV_LAST = DIV_W'(OSC_DIV - 1);

  // Regulator enable hold delay, ms and oscillator ticks
  localparam int HOLD_MIN_MS = 300;
  localparam int HOLD_MAX_MS = 1000;
  localparam int HOLD_DEF_MS = 650;
  localparam int HOLD_W      = 19;

  // Transmit driver hold, us and ticks
  localparam int TX_HOLD_US = 20;
  localparam int TXH_W      = 4;
  localparam logic [TXH_W-1:0] TX_HOLD_TICKS = TXH_W'(TX_HOLD_US * OSC_KHZ / 1000);

  // Wake-up level deglitch, us and clock cycles
  localparam int HV_FILT_US = 10;
  localparam int HVF_W      = 10;
  localparam logic [HVF_W-1:0] HV_FILT_LAST = HVF_W'(HV_FILT_US * CLK_MHZ - 1);

  // Register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_HOLD   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;

  // Status fields
  localparam int ST_REG_EN   = 0;
  localparam int ST_HV_FLAG  = 1;
  localparam int ST_STATE_LO = 2;
  localparam int ST_UV       = 5;
  localparam int ST_GND_LOW  = 6;
  localparam int ST_RXD      = 7;
  localparam int ST_MODE_LO  = 8;
  localparam int ST_TX_EN    = 10;
  localparam int ST_LOAD_SW  = 11;

  // Mode pins, bit0 first
  typedef enum logic [1:0] {
    MODE_SLEEP = 2'h0,
    MODE_HIGH_VOLTAGE_WAKEUP_FLAG  = 2'h1,
    MODE_HS    = 2'h2,
    MODE_NORM  = 2'h3
  } sws_mode_e;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_SLEEP  = 3'h1,
    ST_WAKE   = 3'h2,
    ST_ACTIVE = 3'h4
  } sws_state_e;

  // Analog sensing inputs
  typedef struct packed {
    logic undervolt;
    logic gnd_low;
    logic hv_level;
    logic bus_dom;
  } sws_sense_s;

  // Transmit driver controls
  typedef struct packed {
    logic drive;
    logic enable;
    logic hv;
    logic shape;
  } sws_drv_s;

endpackage : sws_pkg

// ### testbench/sws_host_model.sv
// Host microcontroller and supply regulator model for the sleep/wake bench
module sws_host_model (
  // Clock and regulator control
  input  wire logic       ref_clk,
  input  wire logic       regulator_enable_out,
  // Bench commands to the host
  input  wire logic       host_take,
  input  wire logic [1:0] host_mode,
  // Mode pins and supply state
  output logic            mode_select_bit0,
  output logic            mode_select_bit1,
  output logic            vcc_up
);
  timeunit 1ns;
  timeprecision 1ps;

  // Regulator output follows its enable; host is dead without it
  always_ff @(posedge ref_clk) begin
    vcc_up <= regulator_enable_out;
  end

  // Pins fall to the pulldown level unless a powered host drives them
  assign mode_select_bit0 = (vcc_up && host_take) ? host_mode[1] : 1'b0;
  assign mode_select_bit1 = (vcc_up && host_take) ? host_mode[0] : 1'b0;
endmodule : sws_host_model

// ### testbench/tb.sv
// Self-checking bench for the sleep/wake control block
module tb;
  import sws_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk, reset, txd_in, host_take, vcc_up, mode_select_bit0, mode_select_bit1;
  logic regulator_enable_out, load_switch_closed_out, high_voltage_wakeup_flag;
  logic rxd_in, rxd_out, rxd_oe, avs_read, avs_write, avs_waitrequest;
  logic [1:0] host_mode;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  sws_sense_s sense;
  sws_drv_s transmit_driver;
  int bad_count, compares, n;

  // Open-drain receive line with pull-up
  assign rxd_in = rxd_oe ? rxd_out : 1'b1;

  sws_sleep_wake_control #(
    .HOLD_MIN_TICKS (19'h4),
    .HOLD_MAX_TICKS (19'h28),
    .HOLD_DEF_TICKS (19'h8)
  ) u_dut (
    .ref_clk (ref_clk), .reset (reset),
    .mode_select_bit0 (mode_select_bit0), .mode_select_bit1 (mode_select_bit1),
    .txd_in (txd_in), .sense_in (sense),
    .regulator_enable_out (regulator_enable_out),
    .load_switch_closed_out (load_switch_closed_out),
    .high_voltage_wakeup_flag (high_voltage_wakeup_flag),
    .transmit_driver (transmit_driver),
    .rxd_in (rxd_in), .rxd_out (rxd_out), .rxd_oe (rxd_oe),
    .avs_address (avs_address), .avs_read (avs_read), .avs_write (avs_write),
    .avs_writedata (avs_writedata), .avs_readdata (avs_readdata),
    .avs_waitrequest (avs_waitrequest)
  );

  sws_host_model u_host (
    .ref_clk (ref_clk), .regulator_enable_out (regulator_enable_out),
    .host_take (host_take), .host_mode (host_mode),
    .mode_select_bit0 (mode_select_bit0), .mode_select_bit1 (mode_select_bit1),
    .vcc_up (vcc_up)
  );

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Counted comparison
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic print_verdict();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : cyc

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic av(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
    int k;
    @(posedge ref_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= adr;
    avs_writedata <= wd;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 50) begin
      bad_count++;
      $display("[ERR] bus answer timed out");
      print_verdict();
    end
  endtask : av

  task automatic rdchk(input string nm, input logic [3:0] adr, input logic [31:0] exp);
    av(1'b0, adr, 32'h0);
    chk(nm, rd, exp);
  endtask : rdchk

  // Bounded wait for enable (sel 0) or wake flag (sel 1) to reach v
  task automatic wait_sig(input bit sel, input logic v, input int lim);
    n = 0;
    while (((sel ? high_voltage_wakeup_flag : regulator_enable_out) !== v) && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= lim) begin
      bad_count++;
      $display("[ERR] wait timed out");
      print_verdict();
    end
  endtask : wait_sig

  task automatic t_reset();
    cyc(2);
    chk("reg_en", regulator_enable_out, 0);
    chk("driver", transmit_driver[3:1], 0);
    chk("rxd_oe", rxd_oe, 0);
    rdchk("status", REG_STATUS, 32'h884);
    $display("done: reset");
  endtask : t_reset

  task automatic t_regs();
    rdchk("hold_def", REG_HOLD, 32'h8);
    av(1'b1, REG_HOLD, 32'h64);
    rdchk("hold_max", REG_HOLD, 32'h28);
    av(1'b1, REG_HOLD, 32'h2);
    rdchk("hold_min", REG_HOLD, 32'h4);
    av(1'b1, 4'h8, 32'hff);
    rdchk("unmapped", 4'h8, 32'h0);
    av(1'b1, REG_STATUS, 32'h0);
    rdchk("status_ro", REG_STATUS, 32'h884);
    av(1'b1, REG_HOLD, 32'h5);
    rdchk("hold", REG_HOLD, 32'h5);
    $display("done: registers");
  endtask : t_regs

  task automatic t_wake();
    sense.hv_level <= 1'b1;
    cyc(500);
    sense.hv_level <= 1'b0;
    cyc(20);
    chk("glitch_flag", high_voltage_wakeup_flag, 0);
    chk("glitch_en", regulator_enable_out, 0);
    sense.hv_level <= 1'b1;
    wait_sig(1'b1, 1'b1, 1200);
    chk("deglitch_time", 32'(n inside {[995:1005]}), 1);
    cyc(1);
    chk("wake_en", regulator_enable_out, 1);
    wait_sig(1'b0, 1'b0, 2000);
    chk("hold_time", 32'(n inside {[795:1205]}), 1);
    cyc(5);
    chk("stay_asleep", regulator_enable_out, 0);
    sense.hv_level <= 1'b0;
    $display("done: wake and hold");
  endtask : t_wake

  task automatic t_host();
    cyc(5);
    host_take <= 1'b1;
    host_mode <= 2'h3;
    sense.hv_level <= 1'b1;
    wait_sig(1'b0, 1'b1, 1200);
    sense.hv_level <= 1'b0;
    cyc(2000);
    chk("kept_en", regulator_enable_out, 1);
    av(1'b0, REG_STATUS, 32'h0);
    chk("active", rd[4:2], 3'h4);
    for (int m = 1; m < 4; m++) begin
      host_mode <= 2'(m);
      txd_in <= 1'b0;
      cyc(4);
      chk("hv_drive", transmit_driver.hv, (m == 1));
      chk("shape", transmit_driver.shape, (m != 2));
      chk("dominant", transmit_driver.drive, 1);
      rdchk("mode", REG_STATUS, 32'h891 | (32'(m) << 8) | 32'h400);
    end
    txd_in <= 1'b1;
    cyc(3);
    chk("recessive", transmit_driver.drive, 0);
    cyc(1000);
    chk("tx_hold_on", transmit_driver.enable, 1);
    cyc(1400);
    chk("tx_hold_off", transmit_driver.enable, 0);
    $display("done: host control and driver");
  endtask : t_host

  task automatic t_sense();
    sense.bus_dom <= 1'b1;
    cyc(3);
    chk("rx_dom", rxd_in, 0);
    txd_in <= 1'b0;
    sense.undervolt <= 1'b1;
    cyc(3);
    chk("uv_drv", transmit_driver[3:1], 0);
    chk("uv_rx", rxd_oe, 0);
    sense <= '0;
    txd_in <= 1'b1;
    cyc(1);
    sense.gnd_low <= 1'b1;
    cyc(3);
    chk("gnd_open", load_switch_closed_out, 0);
    sense.gnd_low <= 1'b0;
    cyc(3);
    chk("gnd_close", load_switch_closed_out, 1);
    host_mode <= 2'h0;
    wait_sig(1'b0, 1'b0, 2000);
    chk("sleep_time", 32'(n inside {[795:1205]}), 1);
    $display("done: sense and sleep");
  endtask : t_sense

  // Main sequence with a global cycle limit
  initial begin
    reset = 1'b1;
    txd_in = 1'b1;
    sense = '0;
    host_take = 1'b0;
    host_mode = 2'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    cyc(20);
    reset <= 1'b0;
    t_reset();
    t_regs();
    t_wake();
    t_host();
    t_sense();
    print_verdict();
  end

  initial begin
    cyc(90000);
    bad_count++;
    $display("[ERR] run limit reached");
    print_verdict();
  end
endmodule : tb
